/* rtl/ssr_consts.svh */
// Bit positions, reset values and error codes for status reporting.
// Assumes the includer compares codes as signed 16-bit values.
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
// Event status bit positions
`define SSR_EV_OPD   0
`define SSR_EV_QRY   2
`define SSR_EV_DEV   3
`define SSR_EV_EXE   4
`define SSR_EV_CMD   5
`define SSR_EV_PWR   7
`define SSR_EV_USED  8'hBD
`define SSR_EV_RST   8'h80
`define SSR_EN_RST   8'hFF
// Operation status
`define SSR_OP_MEASURING_FLAG  4
`define SSR_OP_USED  16'h0010
// Fault input positions, lowest wins
`define SSR_F_CHAR   0
`define SSR_F_SYN    1
`define SSR_F_RANGE  2
`define SSR_F_CONF   3
`define SSR_F_MUCH   4
`define SSR_F_ILL    5
// Error codes (two's complement)
`define SSR_C_NONE   16'sh0000
`define SSR_C_CHAR   16'shFF70
`define SSR_C_SYN    16'shFF55
`define SSR_C_RANGE  16'shFF22
`define SSR_C_CONF   16'shFF23
`define SSR_C_MUCH   16'shFF21
`define SSR_C_ILL    16'shFF20
`define SSR_C_OVF    16'shFEA2
// Class bounds
`define SSR_Q_LO     16'shFE0D
`define SSR_Q_HI     16'shFE70
`define SSR_D_LO     16'shFE71
`define SSR_D_HI     16'shFED4
`define SSR_X_LO     16'shFED5
`define SSR_X_HI     16'shFF38
`define SSR_M_LO     16'shFF39
`define SSR_M_HI     16'shFF9C
`define SSR_P_LO     16'sh0001
`endif

/* rtl/ssr_pkg.sv */
// Types shared by the status reporting block.
// Assumes nothing of its surroundings.
`default_nettype none
package ssr_pkg;
  typedef logic signed [15:0] ssr_code_t;
  typedef logic [7:0]         ssr_byte_t;
  typedef logic [15:0]        ssr_word_t;
  typedef logic [5:0]         ssr_fault_t;
endpackage
`default_nettype wire

/* rtl/ssr_status.sv */
// Status and event reporting: event status, operation status,
// response queue and error queue, with status byte summary bits.
// Assumes the command parser drives one-cycle strobes on clk_sys_i.
//
// How it works
// [RULE1] Event status query returns contents then clears; clear-status clears too.
// [RULE2] An event bit sets only while its enable mask bit is set.
// [RULE3] Bit 0 sets when operations finish or query results are ready; only operation_done_flag_i sets it here.
// [RULE4] Event bits 1 and 6 always read zero.
// [RULE5] Bit 2 sets on query faults, codes -499 to -400.
// [RULE6] Bit 3 sets on device faults, -399 to -300 or 1 to 32767.
// [RULE7] Bit 4 sets on execution faults, codes -299 to -200.
// [RULE8] Bit 5 sets on command faults, codes -199 to -100.
// [RULE9] Bit 7 sets at power-up and never drives error-available.
// [RULE10] Operation status is 16 bits, only bit 4 measuring is live.
// [RULE11] Responses sit in a FIFO; message-available while it is non-empty.
// [RULE12] A new command discards unread responses.
// [RULE13] Error queue is FIFO, 16 deep, oldest first on each read.
// [RULE14] Clear-status empties the error queue.
// [RULE15] Queue overflow records code -350.
// [RULE16] Character data over 12 characters gives code -144.
// [RULE17] Bad syntax gives code -171.
// [RULE18] Right type but out of range gives code -222.
// [RULE19] Legal data not runnable in current state gives -221.
// [RULE20] Too much data in a parameter gives -223.
// [RULE21] Value not permitted for the command gives -224.
// [RULE22] Event summary bit set while event status is non-zero.
// [RULE23] Error-available set while the error queue holds entries.
// [RULE24] Full queue drops new errors, newest entry becomes overflow code.
// [RULE25] Reading an empty error queue returns code 0.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.svh"

module ssr_status #(
  parameter int OUT_DEPTH = 16,
  parameter int ERR_DEPTH = 16
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              cmd_new_i,
  input  wire logic              cls_i,
  input  wire logic              sevt_rd_i,
  input  wire logic              sevt_en_wr_i,
  input  wire ssr_pkg::ssr_byte_t sevt_en_data_i,
  output var  ssr_pkg::ssr_byte_t sevt_data_o,
  input  wire logic              operation_done_flag_i,
  input  wire logic              measuring_flag_i,
  input  wire logic              opst_rd_i,
  output var  ssr_pkg::ssr_word_t opst_data_o,
  input  wire ssr_pkg::ssr_fault_t fault_i,
  input  wire logic              err_valid_i,
  input  wire ssr_pkg::ssr_code_t err_code_i,
  input  wire logic              err_rd_i,
  output var  ssr_pkg::ssr_code_t err_code_o,
  output logic                   err_code_valid_o,
  input  wire logic              resp_wr_i,
  input  wire ssr_pkg::ssr_byte_t resp_data_i,
  output logic                   resp_full_o,
  input  wire logic              resp_rd_i,
  output var  ssr_pkg::ssr_byte_t resp_data_o,
  output logic                   resp_valid_o,
  output logic                   message_available_o,
  output logic                   error_available_o,
  output logic                   event_summary_bit_o
);
  import ssr_pkg::*;

  localparam int OAW = $clog2(OUT_DEPTH);
  localparam int EAW = $clog2(ERR_DEPTH);

  // ==========================================================
  // Fault to code mapping
  // ==========================================================
  // Priority chain: only one code can enter the queue per cycle
  function automatic ssr_code_t fault_code(input ssr_fault_t f);
    ssr_code_t c;
    c = `SSR_C_NONE;
    // [RULE16] too long text
    if (f[`SSR_F_CHAR])       c = `SSR_C_CHAR;
    // [RULE17] syntax fault
    else if (f[`SSR_F_SYN])   c = `SSR_C_SYN;
    // [RULE18] range fault
    else if (f[`SSR_F_RANGE]) c = `SSR_C_RANGE;
    // [RULE19] settings conflict
    else if (f[`SSR_F_CONF])  c = `SSR_C_CONF;
    // [RULE20] too much data
    else if (f[`SSR_F_MUCH])  c = `SSR_C_MUCH;
    // [RULE21] illegal value
    else if (f[`SSR_F_ILL])   c = `SSR_C_ILL;
    return c;
  endfunction

  // Coded faults win over the external code in the same cycle
  wire logic      new_vld = (|fault_i) | err_valid_i;
  wire ssr_code_t new_cd  = (|fault_i) ? fault_code(fault_i) : err_code_i;

  // ==========================================================
  // Error queue
  // ==========================================================
  ssr_code_t         eq_mem [ERR_DEPTH];
  logic [EAW-1:0]    eq_wr_q, eq_rd_q, eq_wr_d, eq_rd_d;
  logic [EAW:0]      eq_cnt_q, eq_cnt_d;
  logic              ovf_q;
  ssr_code_t         err_code_q;
  logic              err_vld_q, eav_q;

  // Pop and push may share a cycle even when full
  wire logic eq_empty = (eq_cnt_q == '0);
  wire logic eq_full  = (eq_cnt_q == (EAW+1)'(ERR_DEPTH));
  wire logic eq_pop   = err_rd_i & ~cls_i & ~eq_empty;
  wire logic eq_push  = new_vld & ~cls_i & (~eq_full | eq_pop);
  // [RULE24] one overflow mark per full episode
  wire logic eq_ovf   = new_vld & ~cls_i & eq_full & ~eq_pop & ~ovf_q;
  wire logic [EAW-1:0] eq_last = eq_wr_q - 1'b1;

  // [RULE14] clear-status resets pointers and count
  assign eq_wr_d  = cls_i ? '0 : eq_wr_q + EAW'(eq_push);
  assign eq_rd_d  = cls_i ? '0 : eq_rd_q + EAW'(eq_pop);
  assign eq_cnt_d = cls_i ? '0 : eq_cnt_q + (EAW+1)'(eq_push) - (EAW+1)'(eq_pop);

  // Storage has no reset; only pointers define validity
  always_ff @(posedge clk_sys_i)
  begin
    if (eq_push)
      eq_mem[eq_wr_q] <= new_cd;
    // [RULE15] overflow code replaces newest entry
    else if (eq_ovf)
      eq_mem[eq_last] <= `SSR_C_OVF;
  end

  // Pointer and flag state
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      eq_wr_q  <= '0;
      eq_rd_q  <= '0;
      eq_cnt_q <= '0;
      ovf_q    <= 1'b0;
    end
    else
    begin
      eq_wr_q  <= eq_wr_d;
      eq_rd_q  <= eq_rd_d;
      eq_cnt_q <= eq_cnt_d;
      ovf_q    <= eq_ovf | (ovf_q & ~eq_pop & ~cls_i);
    end
  end

  // [RULE13] oldest entry answers each read
  // [RULE25] empty queue answers no error
  wire ssr_code_t eq_head = eq_pop ? eq_mem[eq_rd_q] : `SSR_C_NONE;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      err_code_q <= `SSR_C_NONE;
      err_vld_q  <= 1'b0;
      eav_q      <= 1'b0;
    end
    else
    begin
      if (err_rd_i)
        err_code_q <= eq_head;
      err_vld_q <= err_rd_i;
      // [RULE23] error-available from queue fill only
      eav_q     <= (eq_cnt_d != '0);
    end
  end

  // ==========================================================
  // Event status
  // ==========================================================
  ssr_byte_t sevt_q, sevt_en_q, sevt_out_q;
  logic      esum_q;

  // Code of this cycle's event, for classing; a dropped code still
  // flags its own class, and the overflow mark adds the device class
  wire ssr_code_t ev_cd = new_cd;
  wire logic      ev_on = new_vld;
  wire logic c_qry = ev_on & (ev_cd >= `SSR_Q_LO) & (ev_cd <= `SSR_Q_HI);
  wire logic c_dev = (ev_on & (((ev_cd >= `SSR_D_LO) & (ev_cd <= `SSR_D_HI))
                               | (ev_cd >= `SSR_P_LO))) | eq_ovf;
  wire logic c_exe = ev_on & (ev_cd >= `SSR_X_LO) & (ev_cd <= `SSR_X_HI);
  wire logic c_cmd = ev_on & (ev_cd >= `SSR_M_LO) & (ev_cd <= `SSR_M_HI);

  ssr_byte_t ev_raw;
  always_comb
  begin
    ev_raw = '0;
    // [RULE3] operation done
    ev_raw[`SSR_EV_OPD] = operation_done_flag_i;
    // [RULE5] query fault
    ev_raw[`SSR_EV_QRY] = c_qry;
    // [RULE6] device fault
    ev_raw[`SSR_EV_DEV] = c_dev;
    // [RULE7] execution fault
    ev_raw[`SSR_EV_EXE] = c_exe;
    // [RULE8] command fault
    ev_raw[`SSR_EV_CMD] = c_cmd;
  end

  // [RULE2] mask gates setting
  // [RULE4] unused bits forced low
  wire ssr_byte_t ev_set = ev_raw & sevt_en_q & `SSR_EV_USED;
  // [RULE1] clear on read or clear-status, new events survive
  wire logic      ev_clr = sevt_rd_i | cls_i;
  wire ssr_byte_t sevt_d = ev_clr ? ev_set : (sevt_q | ev_set);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      // [RULE9] power-up mark seeded by reset
      sevt_q     <= `SSR_EV_RST;
      sevt_en_q  <= `SSR_EN_RST;
      sevt_out_q <= '0;
      esum_q     <= 1'b0;
    end
    else
    begin
      sevt_q <= sevt_d;
      if (sevt_en_wr_i)
        sevt_en_q <= sevt_en_data_i;
      // [RULE1] answer holds contents before clear
      if (sevt_rd_i)
        sevt_out_q <= sevt_q;
      // [RULE22] summary of what is left
      esum_q <= (sevt_d != '0);
    end
  end

  // ==========================================================
  // Operation status
  // ==========================================================
  ssr_word_t opst_out_q;
  // [RULE10] only measuring bit is live
  wire ssr_word_t opst_v = (16'(measuring_flag_i) << `SSR_OP_MEASURING_FLAG) & `SSR_OP_USED;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      opst_out_q <= '0;
    else if (opst_rd_i)
      opst_out_q <= opst_v;
  end

  // ==========================================================
  // Response queue
  // ==========================================================
  ssr_byte_t      oq_mem [OUT_DEPTH];
  logic [OAW-1:0] oq_wr_q, oq_rd_q, oq_wr_d, oq_rd_d;
  logic [OAW:0]   oq_cnt_q, oq_cnt_d;
  ssr_byte_t      resp_q;
  logic           resp_vld_q, oq_full_q, mav_q;

  // A flush frees room, so the new command's first byte is kept
  wire logic oq_full = (oq_cnt_q == (OAW+1)'(OUT_DEPTH));
  wire logic oq_push = resp_wr_i & (~oq_full | cmd_new_i);
  wire logic oq_pop  = resp_rd_i & ~cmd_new_i & (oq_cnt_q != '0);

  // [RULE12] flush moves read pointer to write pointer
  assign oq_wr_d  = oq_wr_q + OAW'(oq_push);
  assign oq_rd_d  = cmd_new_i ? oq_wr_q : oq_rd_q + OAW'(oq_pop);
  assign oq_cnt_d = cmd_new_i ? (OAW+1)'(oq_push)
                  : oq_cnt_q + (OAW+1)'(oq_push) - (OAW+1)'(oq_pop);

  // [RULE11] first-in first-out storage
  always_ff @(posedge clk_sys_i)
  begin
    if (oq_push)
      oq_mem[oq_wr_q] <= resp_data_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      oq_wr_q    <= '0;
      oq_rd_q    <= '0;
      oq_cnt_q   <= '0;
      resp_q     <= '0;
      resp_vld_q <= 1'b0;
      oq_full_q  <= 1'b0;
      mav_q      <= 1'b0;
    end
    else
    begin
      oq_wr_q    <= oq_wr_d;
      oq_rd_q    <= oq_rd_d;
      oq_cnt_q   <= oq_cnt_d;
      if (oq_pop)
        resp_q <= oq_mem[oq_rd_q];
      resp_vld_q <= oq_pop;
      oq_full_q  <= (oq_cnt_d == (OAW+1)'(OUT_DEPTH));
      // [RULE11] message-available from fill
      mav_q      <= (oq_cnt_d != '0);
    end
  end

  // Outputs straight from flops
  assign sevt_data_o         = sevt_out_q;
  assign opst_data_o         = opst_out_q;
  assign err_code_o          = err_code_q;
  assign err_code_valid_o    = err_vld_q;
  assign resp_data_o         = resp_q;
  assign resp_valid_o        = resp_vld_q;
  assign resp_full_o         = oq_full_q;
  assign message_available_o = mav_q;
  assign error_available_o   = eav_q;
  assign event_summary_bit_o = esum_q;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_read_answer:   assert property (sevt_rd_i |=> sevt_data_o == $past(sevt_q)) // RULE1
    else $error("event status answer wrong");
  a_read_clear:    assert property (((sevt_rd_i || cls_i) && ev_set == '0) |=> sevt_q == '0) // RULE1
    else $error("event status not cleared");
  a_mask_gate:     assert property ($past(rst_n_i) |-> // RULE2
    ((sevt_q & ~$past(sevt_q) & ~$past(sevt_en_q)) == '0))
    else $error("event bit set while masked");
  a_opd_sets:      assert property ((operation_done_flag_i && sevt_en_q[`SSR_EV_OPD]) // RULE3
    |=> sevt_q[`SSR_EV_OPD]) else $error("operation done lost");
  a_unused_zero:   assert property ((sevt_q & ~`SSR_EV_USED) == '0) // RULE4
    else $error("unused event bit set");
  a_cmd_class:     assert property ((fault_i[`SSR_F_SYN] && sevt_en_q[`SSR_EV_CMD]) // RULE8
    |=> sevt_q[`SSR_EV_CMD]) else $error("command fault bit missing");
  a_opst_mask:     assert property ((opst_data_o & ~`SSR_OP_USED) == '0) // RULE10
    else $error("operation status unused bit");
  a_flush_queue:   assert property ((cmd_new_i && !resp_wr_i) // RULE12
    |=> !message_available_o ##1 !resp_valid_o) else $error("responses not flushed");
  a_queue_bound:   assert property (eq_cnt_q <= (EAW+1)'(ERR_DEPTH)) // RULE13
    else $error("error queue over depth");
  a_cls_empty:     assert property (cls_i |=> !error_available_o && eq_empty) // RULE14
    else $error("clear-status left errors");
  a_ovf_mark:      assert property (eq_ovf |=> eq_mem[$past(eq_last)] == `SSR_C_OVF) // RULE15
    else $error("overflow code not recorded");
  a_empty_none:    assert property ((err_rd_i && eq_empty) // RULE25
    |=> err_code_valid_o && err_code_o == `SSR_C_NONE) else $error("empty read not zero");
  a_eav_queue:     assert property (error_available_o == !eq_empty) // RULE23
    else $error("error-available mismatch");

  c_overflow:  cover property (eq_ovf ##1 eq_pop);
  c_flush:     cover property (message_available_o ##1 cmd_new_i);
  c_read_evt:  cover property (sevt_rd_i && sevt_q[`SSR_EV_CMD]);
  c_full_resp: cover property (resp_full_o ##1 resp_valid_o);
endmodule

`default_nettype wire

/* tb/ssr_host.sv */
// Remote controller model: one-cycle queries and commands.
// Assumes the bench calls send() from one process only.
`timescale 1ns/1ps
`default_nettype none

module ssr_host (
  input  wire logic               clk_sys_i,
  output logic [6:0]              req_o,
  output ssr_pkg::ssr_byte_t      en_data_o
);
  import ssr_pkg::*;

  // ==========================================
  // Request driver
  initial
  begin
    req_o     = 7'h00;
    en_data_o = 8'h00;
  end

  // Mask data inverted after use so a stale value never looks valid
  task automatic send(input logic [6:0] r, input ssr_byte_t d);
    @(posedge clk_sys_i);
    #2;
    req_o     = r;
    en_data_o = d;
    @(posedge clk_sys_i);
    #2;
    req_o     = 7'h00;
    en_data_o = ~d;
  endtask
endmodule

`default_nettype wire

/* tb/ssr_status_bench.sv */
// Self-checking bench for the status reporting block.
// Assumes design files and the controller model compile first.
`timescale 1ns/1ps
`default_nettype none

module ssr_status_bench;
  import ssr_pkg::*;
  localparam logic [6:0] CMD = 7'h40, CLS = 7'h20, SRD = 7'h10, EWR = 7'h08;
  localparam logic [6:0] ORD = 7'h04, ERD = 7'h02, RRD = 7'h01;
  logic       clk_sys_i, rst_n_i, opd, measuring_flag, ev, rw, evld, rvld, rfull, message_available, error_available, event_summary_bit;
  logic [6:0] req;
  ssr_byte_t  en_d, sevt, rdat, wdat;
  ssr_fault_t fault;
  ssr_code_t  code, ecode, c;
  ssr_word_t  opst;
  ssr_code_t  eq[20];
  ssr_byte_t  rb[3];
  int         seed = 89300;
  int         error_cnt = 0;
  int         n_tests = 0;
  // Class upper bounds and matching event bits
  ssr_code_t  hi[5] = '{-16'sd400, -16'sd300, -16'sd200, -16'sd100, 16'sd32767};
  ssr_byte_t  cb[5] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h08};
  ssr_code_t  fc[6] = '{-16'sd144, -16'sd171, -16'sd222, -16'sd221, -16'sd223, -16'sd224};

  // ==========================================
  // Clock, controller model and design
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  ssr_host i_host (.clk_sys_i(clk_sys_i), .req_o(req), .en_data_o(en_d));

  ssr_status i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_new_i(req[6]), .cls_i(req[5]),
    .sevt_rd_i(req[4]), .sevt_en_wr_i(req[3]), .sevt_en_data_i(en_d),
    .sevt_data_o(sevt), .operation_done_flag_i(opd), .measuring_flag_i(measuring_flag),
    .opst_rd_i(req[2]), .opst_data_o(opst), .fault_i(fault), .err_valid_i(ev),
    .err_code_i(code), .err_rd_i(req[1]), .err_code_o(ecode),
    .err_code_valid_o(evld), .resp_wr_i(rw), .resp_data_i(wdat),
    .resp_full_o(rfull), .resp_rd_i(req[0]), .resp_data_o(rdat),
    .resp_valid_o(rvld), .message_available_o(message_available), .error_available_o(error_available),
    .event_summary_bit_o(event_summary_bit)
  );

  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One-cycle pulse on the internal sources
  task automatic src(input ssr_fault_t f, input logic e, input ssr_code_t cd,
                     input logic o, input logic w, input ssr_byte_t d);
    @(posedge clk_sys_i);
    #2;
    {fault, ev, code, opd, rw, wdat} = {f, e, cd, o, w, d};
    @(posedge clk_sys_i);
    #2;
    {fault, ev, code, opd, rw, wdat} = {6'h00, 1'b0, ~cd, 1'b0, 1'b0, ~d};
  endtask

  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    final_report;
  end

  // ==========================================
  // Main sequence
  initial
  begin
    {rst_n_i, fault, ev, code, opd, measuring_flag, rw, wdat} = '0;
    repeat (12) @(posedge clk_sys_i);
    #2;
    rst_n_i = 1'b1;
    @(posedge clk_sys_i);
    #2;
    chk("summary", event_summary_bit, 1'b1);
    chk("eav", error_available, 1'b0);
    host_read_clear();
    // Error classes with random codes
    for (int k = 0; k < 5; k++)
    begin
      c = hi[k] - ssr_code_t'($random(seed) & 63);
      src(6'h00, 1'b1, c, 1'b0, 1'b0, 8'h00);
      chk("eav", error_available, 1'b1);
      i_host.send(SRD, 8'h00);
      chk("class", sevt, cb[k]);
      i_host.send(ERD, 8'h00);
      chk("code", ecode, c);
    end
    // Coded faults beat a simultaneous external code
    for (int i = 0; i < 6; i++)
    begin
      src(ssr_fault_t'(1 << i), 1'b1, 16'sh0005, 1'b0, 1'b0, 8'h00);
      i_host.send(ERD, 8'h00);
      chk("fcode", ecode, fc[i]);
      chk("evalid", evld, 1'b1);
      chk("eav", error_available, 1'b0);
      i_host.send(SRD, 8'h00);
      chk("fclass", sevt, (i < 2) ? 8'h20 : 8'h10);
    end
    // Masked command fault beside an operation done
    i_host.send(EWR, 8'hDF);
    src(6'h00, 1'b1, -16'sd150, 1'b1, 1'b0, 8'h00);
    i_host.send(SRD, 8'h00);
    chk("mask", sevt, 8'h01);
    i_host.send(ERD, 8'h00);
    i_host.send(EWR, 8'hFF);
    measuring_flag = 1'b1;
    i_host.send(ORD, 8'h00);
    chk("opst", opst, 16'h0010);
    measuring_flag = 1'b0;
    i_host.send(ORD, 8'h00);
    chk("opst", opst, 16'h0000);
    // Overflow: 20 pushes into 16 places, then one extra read of the empty queue
    for (int k = 0; k < 20; k++)
    begin
      eq[k] = -16'sd101 - ssr_code_t'($random(seed) & 63);
      src(6'h00, 1'b1, eq[k], 1'b0, 1'b0, 8'h00);
    end
    for (int k = 0; k < 17; k++)
    begin
      i_host.send(ERD, 8'h00);
      chk("ovq", ecode, (k == 15) ? -16'sd350 : (k == 16) ? 16'sh0000 : eq[k]);
    end
    chk("eav", error_available, 1'b0);
    i_host.send(SRD, 8'h00);
    chk("ovf", sevt, 8'h28);
    // Clear-status empties queue and event status
    src(6'h00, 1'b1, -16'sd250, 1'b0, 1'b0, 8'h00);
    src(6'h00, 1'b1, 16'sd77, 1'b0, 1'b0, 8'h00);
    i_host.send(CLS, 8'h00);
    chk("eav", error_available, 1'b0);
    chk("summary", event_summary_bit, 1'b0);
    i_host.send(ERD, 8'h00);
    chk("empty", ecode, 16'h0000);
    // Response queue order, then flush on a new command
    for (int k = 0; k < 3; k++)
    begin
      rb[k] = ssr_byte_t'($random(seed));
      src(6'h00, 1'b0, 16'sh0000, 1'b0, 1'b1, rb[k]);
    end
    chk("mav", message_available, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      i_host.send(RRD, 8'h00);
      chk("resp", {rvld, rdat}, {1'b1, rb[k]});
    end
    i_host.send(CMD, 8'h00);
    chk("mav", message_available, 1'b0);
    // Fill the response queue to its depth, then flush it
    for (int k = 0; k < 16; k++)
    begin
      src(6'h00, 1'b0, 16'sh0000, 1'b0, 1'b1, ssr_byte_t'($random(seed)));
      chk("rfull", rfull, k == 15);
    end
    chk("mav", message_available, 1'b1);
    i_host.send(CMD, 8'h00);
    chk("rfull", rfull, 1'b0);
    chk("mav", message_available, 1'b0);
    final_report;
  end

  // Power-up bit read once, then the clear is checked
  task automatic host_read_clear;
    i_host.send(SRD, 8'h00);
    chk("pwr", sevt, 8'h80);
    chk("summary", event_summary_bit, 1'b0);
    i_host.send(SRD, 8'h00);
    chk("cleared", sevt, 8'h00);
  endtask
endmodule

`default_nettype wire
